// ==== verilog/digital_io_process_image.sv ====
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/10ps
module digital_io_process_image #(
  parameter int PTC_CH  = 8,
  parameter int WIDE_CH = 16,
  parameter int TWO_CH  = 2
) (
  input  wire logic                    sys_clk,
  input  wire logic                    resetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire dio_image_pkg::apb_req_t apb_req,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  output logic                         irq,
  input  wire dio_image_pkg::ptc_sense_t ptc_sense,
  output logic [PTC_CH-1:0]            channel_switch_off,
  input  wire logic [WIDE_CH-1:0]      wide_level,
  output logic                         one_do,
  input  wire logic                    one_manual,
  output logic [TWO_CH-1:0]            two_do,
  input  wire logic [TWO_CH-1:0]       two_diag
);
  import dio_image_pkg::*;

  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // Sampled field inputs
  // ----------------------------------------------------------------
  logic [PTC_CH-1:0]  level_q;
  logic [PTC_CH-1:0]  fault_q;
  logic [WIDE_CH-1:0] wide_q;
  logic               manual_q;
  logic [TWO_CH-1:0]  diag_q;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      level_q  <= '0;
      fault_q  <= '0;
      wide_q   <= '0;
      manual_q <= 1'b0;
      diag_q   <= '0;
    end else begin
      level_q  <= ptc_sense.sensed_input_level;
      fault_q  <= ptc_sense.fault;
      wide_q   <= wide_level;
      manual_q <= one_manual;
      diag_q   <= two_diag;
    end
  end

  // ----------------------------------------------------------------
  // Bus handshake
  // ----------------------------------------------------------------
  bus_state_t st_q;
  logic       pready_q;
  logic       pslverr_q;
  logic [31:0] prdata_q;

  wire  [7:0] addr      = apb_req.paddr;
  wire        access    = psel && penable;
  wire        commit    = access && pready_q;
  wire        wr_commit = commit && apb_req.pwrite;
  wire        rd_commit = commit && !apb_req.pwrite;

  wire hit_ptc_in   = at(addr, OFF_PTC_IN);
  wire hit_ptc_out  = at(addr, OFF_PTC_OUT);
  wire hit_wide_in  = at(addr, OFF_WIDE_IN);
  wire hit_one_out  = at(addr, OFF_ONE_OUT);
  wire hit_one_in   = at(addr, OFF_ONE_IN);
  wire hit_two_out  = at(addr, OFF_TWO_OUT);
  wire hit_two_diag = at(addr, OFF_TWO_DIAG);
  wire hit_irq_stat = at(addr, OFF_IRQ_STAT);
  wire hit_irq_mask = at(addr, OFF_IRQ_MASK);
  wire mapped = hit_ptc_in | hit_ptc_out | hit_wide_in | hit_one_out
              | hit_one_in | hit_two_out | hit_two_diag | hit_irq_stat
              | hit_irq_mask;

  // ----------------------------------------------------------------
  // Output image and interrupt mask registers
  // ----------------------------------------------------------------
  logic [PTC_CH-1:0] chan_off_q;
  logic              one_do_q;
  logic [TWO_CH-1:0] two_do_q;
  logic [EV_W-1:0]   mask_q;

  // Reserved first output byte is never stored
  wire wr_ptc_out = wr_commit && hit_ptc_out;
  wire wr_one_out = wr_commit && hit_one_out;
  wire wr_two_out = wr_commit && hit_two_out;
  wire wr_mask    = wr_commit && hit_irq_mask;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      chan_off_q <= OUT_IMAGE_RST[PTC_CH-1:0];
      one_do_q   <= OUT_IMAGE_RST[0];
      two_do_q   <= OUT_IMAGE_RST[TWO_CH-1:0];
      mask_q     <= IRQ_MASK_RST;
    end else begin
      if (wr_ptc_out)
        chan_off_q <= apb_req.pwdata[SECOND_BYTE_LSB +: PTC_CH];
      if (wr_one_out)
        one_do_q <= apb_req.pwdata[0];
      if (wr_two_out)
        two_do_q <= apb_req.pwdata[TWO_CH-1:0];
      if (wr_mask)
        mask_q <= apb_req.pwdata[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  logic [PTC_CH-1:0] fault_prev_q;
  logic              manual_prev_q;
  logic [TWO_CH-1:0] diag_prev_q;
  logic [EV_W-1:0]   status_q;
  logic [EV_W-1:0]   ev;
  logic              irq_q;

  genvar g;
  generate
    for (g = 0; g < PTC_CH; g++) begin : g_fault_ev
      assign ev[EV_FAULT_LSB + g] = fault_q[g] && !fault_prev_q[g];
    end
    for (g = 0; g < TWO_CH; g++) begin : g_diag_ev
      assign ev[EV_DIAG_LSB + g] = diag_q[g] && !diag_prev_q[g];
    end
  endgenerate
  assign ev[EV_MANUAL_BIT] = manual_q ^ manual_prev_q;

  // Set wins over the read clear
  wire [EV_W-1:0] stat_clr = (rd_commit && hit_irq_stat) ? '1 : '0;
  wire [EV_W-1:0] status_d = (status_q & ~stat_clr) | ev;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fault_prev_q  <= '0;
      manual_prev_q <= 1'b0;
      diag_prev_q   <= '0;
      status_q      <= '0;
      irq_q         <= 1'b0;
    end else begin
      fault_prev_q  <= fault_q;
      manual_prev_q <= manual_q;
      diag_prev_q   <= diag_q;
      status_q      <= status_d;
      irq_q         <= |(status_d & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // Read selection, little-endian word image
  // ----------------------------------------------------------------
  wire [31:0] rd_ptc_in  = {16'h0000, fault_q, level_q};
  wire [31:0] rd_ptc_out = {16'h0000, chan_off_q, 8'h00};
  wire [31:0] rd_wide    = {{(32-WIDE_CH){1'b0}}, wide_q};
  wire [31:0] rd_one_out = {31'h0000_0000, one_do_q};
  wire [31:0] rd_one_in  = {31'h0000_0000, manual_q};
  wire [31:0] rd_two_out = {{(32-TWO_CH){1'b0}}, two_do_q};
  wire [31:0] rd_diag    = {{(32-TWO_CH){1'b0}}, diag_q};
  wire [31:0] rd_stat    = {{(32-EV_W){1'b0}}, status_q};
  wire [31:0] rd_mask    = {{(32-EV_W){1'b0}}, mask_q};

  wire [31:0] rd_mux = hit_ptc_in   ? rd_ptc_in  :
                       hit_ptc_out  ? rd_ptc_out :
                       hit_wide_in  ? rd_wide    :
                       hit_one_out  ? rd_one_out :
                       hit_one_in   ? rd_one_in  :
                       hit_two_out  ? rd_two_out :
                       hit_two_diag ? rd_diag    :
                       hit_irq_stat ? rd_stat    :
                       hit_irq_mask ? rd_mask    : RDATA_RST;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_q      <= ST_IDLE;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RDATA_RST;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (access) begin
            st_q      <= ST_ACK;
            pready_q  <= 1'b1;
            pslverr_q <= !mapped;
            prdata_q  <= apb_req.pwrite ? RDATA_RST : rd_mux;
          end
        end
        ST_ACK: begin
          st_q      <= ST_IDLE;
          pready_q  <= 1'b0;
          pslverr_q <= 1'b0;
        end
        default: begin
          st_q     <= ST_IDLE;
          pready_q <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign irq                = irq_q;
  assign channel_switch_off = chan_off_q;
  assign one_do             = one_do_q;
  assign two_do             = two_do_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  sequence s_rd(logic [7:0] off);
    psel && penable && pready && !apb_req.pwrite && apb_req.paddr == off;
  endsequence

  sequence s_wr(logic [7:0] off);
    psel && penable && pready && apb_req.pwrite && apb_req.paddr == off;
  endsequence

  chk_ptc_state_byte: assert property (
    s_rd(OFF_PTC_IN) |-> prdata[7:0] == $past(level_q))
    else $error("state byte mismatch");

  chk_ptc_fault_byte: assert property (
    s_rd(OFF_PTC_IN) |-> prdata[15:8] == $past(fault_q))
    else $error("fault byte mismatch");

  chk_switch_off_wr: assert property (
    s_wr(OFF_PTC_OUT) |=> channel_switch_off == $past(apb_req.pwdata[15:8]))
    else $error("switch-off byte not applied");

  chk_reserved_zero: assert property (
    s_rd(OFF_PTC_OUT) |-> prdata[7:0] == 8'h00 && prdata[31:16] == 16'h0000)
    else $error("reserved byte not zero");

  chk_wide_bytes: assert property (
    s_rd(OFF_WIDE_IN) |-> prdata[15:0] == $past(wide_q))
    else $error("wide input word mismatch");

  chk_one_out_bit: assert property (
    s_wr(OFF_ONE_OUT) |=> one_do == $past(apb_req.pwdata[0]) && $stable(two_do))
    else $error("one-channel output wrong");

  chk_two_out_bits: assert property (
    s_wr(OFF_TWO_OUT) |=> two_do == $past(apb_req.pwdata[1:0]))
    else $error("two-channel output wrong");

  chk_diag_irq: assert property (
    $rose(diag_q[0]) && mask_q[EV_DIAG_LSB]
      && !(psel && penable && pready && !apb_req.pwrite && hit_irq_stat)
      |-> ##[1:2] irq)
    else $error("diagnostic event lost");

  chk_manual_bit: assert property (
    s_rd(OFF_ONE_IN) |-> prdata[0] == $past(manual_q) && prdata[31:1] == '0)
    else $error("manual status wrong");

  chk_handshake_one: assert property (
    $rose(pready) |=> !pready)
    else $error("pready held too long");

  chk_reset_outs: assert property (
    disable iff (1'b0) !resetn |=> channel_switch_off == '0 && two_do == '0 && !one_do)
    else $error("outputs not zero in reset");

  chk_stat_read_clr: assert property (
    psel && penable && pready && !apb_req.pwrite && hit_irq_stat && ev == '0
      |=> status_q == '0)
    else $error("status not cleared by read");

  chk_err_data_zero: assert property (
    psel && penable && pready && pslverr |-> prdata == '0)
    else $error("refused transfer returned data");

  chk_irq_masked: assert property (
    mask_q == '0 |=> !irq)
    else $error("irq raised with all events masked");

endmodule

// ==== verilog/dio_image_pkg.sv ====
package dio_image_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PTC_IN    = 8'h00;
  localparam logic [7:0] OFF_PTC_OUT   = 8'h04;
  localparam logic [7:0] OFF_WIDE_IN   = 8'h08;
  localparam logic [7:0] OFF_ONE_OUT   = 8'h0C;
  localparam logic [7:0] OFF_ONE_IN    = 8'h10;
  localparam logic [7:0] OFF_TWO_OUT   = 8'h14;
  localparam logic [7:0] OFF_TWO_DIAG  = 8'h18;
  localparam logic [7:0] OFF_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] OFF_IRQ_MASK  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int BYTE_W        = 8;
  localparam int FIRST_BYTE_LSB = 0;
  localparam int SECOND_BYTE_LSB = 8;
  localparam int EV_FAULT_LSB  = 0;
  localparam int EV_MANUAL_BIT = 8;
  localparam int EV_DIAG_LSB   = 9;
  localparam int EV_W          = 11;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  OUT_IMAGE_RST = 8'h00;
  localparam logic [10:0] IRQ_MASK_RST  = 11'h000;
  localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]  paddr;
    logic        pwrite;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [7:0] fault;
    logic [7:0] sensed_input_level;
  } ptc_sense_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_ACK  = 2'b10
  } bus_state_t;

endpackage

// ==== testbench/image_master.sv ====
`timescale 1ns/10ps
module image_master (
  input  wire logic                    sys_clk,
  input  wire logic                    pready,
  input  wire logic                    pslverr,
  input  wire logic [31:0]             prdata,
  output logic                         psel,
  output logic                         penable,
  output dio_image_pkg::apb_req_t      apb_req
);
  import dio_image_pkg::*;

  logic keep_zero = 1'h1;

  initial begin
    psel = 1'h0;
    penable = 1'h0;
    apb_req = '0;
  end

  // One APB transfer, held until pready is sampled high
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge sys_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    apb_req <= '{paddr: a, pwrite: w,
                 pwdata: (a == OFF_PTC_OUT && keep_zero) ? (d & 32'hFFFF_FF00) : d};
    @(posedge sys_clk);
    penable <= 1'h1;
    // Waits for the answer; only the bench watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import dio_image_pkg::*;

  logic        sys_clk = 1'h0;
  logic        resetn = 1'h0;
  logic        psel, penable, pready, pslverr, irq, one_do, one_manual;
  apb_req_t    apb_req;
  ptc_sense_t  ptc_sense;
  logic [31:0] prdata;
  logic [7:0]  channel_switch_off;
  logic [15:0] wide_level;
  logic [1:0]  two_do, two_diag;
  int          n_fail = 0;
  int          checks_done = 0;

  always #10 sys_clk = ~sys_clk;

  digital_io_process_image dut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .apb_req(apb_req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .ptc_sense(ptc_sense),
    .channel_switch_off(channel_switch_off), .wide_level(wide_level), .one_do(one_do),
    .one_manual(one_manual), .two_do(two_do), .two_diag(two_diag));

  image_master ctrl (.sys_clk(sys_clk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .apb_req(apb_req));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic chk(input string m, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    ctrl.xfer(a, 1'h0, 32'h0000_0000, r, e);
    chk("read data", r, exp);
    chk("read error", {31'h0, e}, 32'h0000_0000);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    ctrl.xfer(a, 1'h1, d, r, e);
    chk("write error", {31'h0, e}, 32'h0000_0000);
  endtask

  task automatic bad(input logic w);
    logic [31:0] r;
    logic        e;
    ctrl.xfer(8'h40, w, 32'hFFFF_FFFF, r, e);
    chk("unmapped error", {31'h0, e}, 32'h0000_0001);
    if (!w) chk("unmapped data", r, 32'h0000_0000);
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    ptc_sense = '0;
    wide_level = 16'h0000;
    one_manual = 1'h0;
    two_diag = 2'h0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
    settle(1);
    chk("outputs after reset", {21'h0, channel_switch_off, one_do, two_do}, 32'h0);
    rd(OFF_PTC_OUT, 32'h0000_0000);
    rd(OFF_ONE_OUT, 32'h0000_0000);
    rd(OFF_TWO_OUT, 32'h0000_0000);
    rd(OFF_IRQ_MASK, 32'h0000_0000);
    @(posedge sys_clk);
    ptc_sense.fault <= 8'h04;
    settle(5);
    chk("masked irq", {31'h0, irq}, 32'h0000_0000);
    rd(OFF_IRQ_STAT, 32'h0000_0004);
    rd(OFF_IRQ_STAT, 32'h0000_0000);
    wr(OFF_IRQ_MASK, 32'h0000_07FF);
    @(posedge sys_clk);
    two_diag <= 2'h2;
    settle(5);
    chk("irq raised", {31'h0, irq}, 32'h0000_0001);
    rd(OFF_IRQ_STAT, 32'h0000_0400);
    settle(2);
    chk("irq cleared", {31'h0, irq}, 32'h0000_0000);
    rd(OFF_TWO_DIAG, 32'h0000_0002);
    @(posedge sys_clk);
    two_diag <= 2'h3;
    settle(5);
    chk("diag0 irq", {31'h0, irq}, 32'h0000_0001);
    rd(OFF_IRQ_STAT, 32'h0000_0200);
    rd(OFF_TWO_DIAG, 32'h0000_0003);
    rd(OFF_TWO_OUT, 32'h0000_0000);
    @(posedge sys_clk);
    one_manual <= 1'h1;
    settle(5);
    rd(OFF_ONE_IN, 32'h0000_0001);
    rd(OFF_IRQ_STAT, 32'h0000_0100);
    for (int i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      ptc_sense <= '{fault: 8'h80 >> i, sensed_input_level: 8'h01 << i};
      settle(3);
      rd(OFF_PTC_IN, {16'h0000, 8'h80 >> i, 8'h01 << i});
    end
    ctrl.keep_zero = 1'h0;
    wr(OFF_PTC_OUT, 32'hFFFF_A5C3);
    ctrl.keep_zero = 1'h1;
    settle(1);
    chk("switch off", {24'h0, channel_switch_off}, 32'h0000_00A5);
    rd(OFF_PTC_OUT, 32'h0000_A500);
    wr(OFF_PTC_OUT, 32'h0000_5A00);
    settle(1);
    chk("switch off", {24'h0, channel_switch_off}, 32'h0000_005A);
    @(posedge sys_clk);
    wide_level <= 16'hB4E1;
    settle(3);
    rd(OFF_WIDE_IN, 32'h0000_B4E1);
    wr(OFF_ONE_OUT, 32'h0000_0003);
    settle(1);
    chk("one output", {31'h0, one_do}, 32'h0000_0001);
    rd(OFF_ONE_OUT, 32'h0000_0001);
    wr(OFF_ONE_OUT, 32'h0000_0002);
    settle(1);
    chk("one output", {31'h0, one_do}, 32'h0000_0000);
    wr(OFF_TWO_OUT, 32'h0000_00FE);
    settle(1);
    chk("two outputs", {30'h0, two_do}, 32'h0000_0002);
    rd(OFF_TWO_OUT, 32'h0000_0002);
    wr(OFF_TWO_OUT, 32'h0000_0001);
    settle(1);
    chk("two outputs", {30'h0, two_do}, 32'h0000_0001);
    bad(1'h0);
    bad(1'h1);
    end_sim;
  end

  initial begin
    repeat (3000) @(posedge sys_clk);
    n_fail++;
    end_sim;
  end
endmodule
